// [mpsrc_defines.vh]
// constants for the mii status and receive clock block
// assumes a 200 mhz core clock and word-indexed wishbone registers
// Function
// - collision asserted when receive activity seen while transmit enable is high
// - at 10 mb/s receive activity comes from the unsquelched line signal
// - at 100 mb/s two non-adjacent zeros in a 10-bit symbol mean activity
// - collision and carrier sense are not synchronised to receive or transmit clock
// - full duplex holds collision low at all times
// - collision pulses as quality error test at 10 mb/s unless config bit 2 suppresses it
// - half duplex carrier sense, repeater off, follows receive or transmit activity
// - full duplex or repeater carrier sense follows receive activity only
// - receive clock is driven out; nibble, valid and error change with it
// - receive clock runs at 2.5 mhz at 10 mb/s, 25 mhz at 100 mb/s
// - 10 mb/s clock locks to line data, then free-runs keeping last phase
// - 100 mb/s clock follows line while link is up, else local reference
// - 10 mb/s source change falls after carrier sense, before receive valid
// - clock realigns once per packet at 10 mb/s, once per link at 100
// - receive valid rises after start delimiter, falls on end delimiter or error
`ifndef MPSRC_DEFINES_VH
`define MPSRC_DEFINES_VH
// register indexes, byte address is four times the index
`define MPSRC_CFG_IDX 6'd18
`define MPSRC_STAT_IDX 6'd19
// config field positions
`define MPSRC_CFG_FDX 0
`define MPSRC_CFG_REP 1
`define MPSRC_CFG_SQE_SUP 2
`define MPSRC_CFG_SPD100 3
`define MPSRC_CFG_RST 16'h0000
// timing
`define MPSRC_CLK_MHZ 200
`define MPSRC_SQE_WAIT_NS 1000
`define MPSRC_SQE_LEN_NS 1000
`define MPSRC_SQE_WAIT_CYC ((`MPSRC_SQE_WAIT_NS * `MPSRC_CLK_MHZ + 999) / 1000)
`define MPSRC_SQE_LEN_CYC ((`MPSRC_SQE_LEN_NS * `MPSRC_CLK_MHZ + 999) / 1000)
// source edges per receive clock half period at 10 mb/s (25 mhz / 10)
`define MPSRC_HALF10 4'd10
`define MPSRC_PREAMBLE 6'd32
`endif

// [mpsrc_buf2.v]
// two-entry valid/ready buffer
// assumes both sides on the same clock; reset is asynchronous, active high
module mpsrc_buf2 #(
  parameter W = 6
) (
  input wire clk,
  input wire rst,
  input wire in_valid,
  output wire in_ready,
  input wire [W-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [W-1:0] out_data
);
  reg [W-1:0] mem [0:1];
  reg wr_ptr;
  reg rd_ptr;
  reg [1:0] count;
  wire push;
  wire pop;

  // honest full and empty from the occupancy count
  assign in_ready = (count != 2'd2);
  assign out_valid = (count != 2'd0);
  assign out_data = mem[rd_ptr];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // storage written by index, no reset needed on data
  always @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // pointers and occupancy
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count <= 2'd0;
    end else begin
      if (push) begin
        wr_ptr <= ~wr_ptr;
      end
      if (pop) begin
        rd_ptr <= ~rd_ptr;
      end
      if (push & ~pop) begin
        count <= count + 2'd1;
      end else if (pop & ~push) begin
        count <= count - 2'd1;
      end
    end
  end
endmodule // mpsrc_buf2

// [mpsrc_top.v]
// mii collision, carrier sense, receive clock and management slave
// assumes pins are asynchronous to clk; decoder inputs share clk
//
// Design decisions made here: the register offsets and the Wishbone interface to the registers.
`include "mpsrc_defines.vh"
module mpsrc_top #(
  parameter [4:0] PHY_ADDR = 5'h01
) (
  input wire clk,
  input wire rst,
  // wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // line side pins
  input wire line_unsquelched,
  input wire line_sym_clk,
  input wire line_sym_bit,
  input wire line_link,
  input wire ref_in,
  // receive decoder, same clock
  input wire dec_valid,
  output wire dec_ready,
  input wire [3:0] dec_nibble,
  input wire dec_sof,
  input wire dec_eof,
  input wire dec_sig_err,
  // mac side
  input wire tx_en,
  output reg col,
  output reg crs,
  output reg rx_clk,
  output reg [3:0] rx_d,
  output reg rx_dv,
  output reg rx_er,
  // management
  input wire mdc,
  input wire mdio_i,
  output reg mdio_o,
  output reg mdio_oe
);
  localparam [15:0] SQE_WAIT = `MPSRC_SQE_WAIT_CYC;
  localparam [15:0] SQE_LEN = `MPSRC_SQE_LEN_CYC;
  // management states, one-hot
  localparam [4:0] M_PRE = 5'b00001;
  localparam [4:0] M_HDR = 5'b00010;
  localparam [4:0] M_TA = 5'b00100;
  localparam [4:0] M_DAT = 5'b01000;
  localparam [4:0] M_END = 5'b10000;

  // two-flop synchronisers for every pin input
  reg [6:0] sync_a;
  reg [6:0] sync_b;
  wire [6:0] pin_raw;
  assign pin_raw = {mdio_i, mdc, tx_en, ref_in, line_link, line_sym_bit,
    line_unsquelched};
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      sync_a <= 7'h00;
      sync_b <= 7'h00;
    end else begin
      sync_a <= pin_raw;
      sync_b <= sync_a;
    end
  end
  wire s_unsq = sync_b[0];
  wire s_sym = sync_b[1];
  wire s_link = sync_b[2];
  wire s_ref = sync_b[3];
  wire s_txen = sync_b[4];
  wire s_mdc = sync_b[5];
  wire s_mdio = sync_b[6];

  // the line clock gets its own pair so the edge detector never sees stage one
  reg lclk_a;
  reg lclk_b;
  reg lclk_c;
  reg ref_c;
  reg mdc_c;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      lclk_a <= 1'b0;
      lclk_b <= 1'b0;
      lclk_c <= 1'b0;
      ref_c <= 1'b0;
      mdc_c <= 1'b0;
    end else begin
      lclk_a <= line_sym_clk;
      lclk_b <= lclk_a;
      lclk_c <= lclk_b;
      ref_c <= s_ref;
      mdc_c <= s_mdc;
    end
  end
  wire line_rise = lclk_b & ~lclk_c;
  wire line_edge = lclk_b ^ lclk_c;
  wire ref_edge = s_ref ^ ref_c;
  wire mdc_rise = s_mdc & ~mdc_c;

  // configuration register, written by wishbone or management frames
  reg [15:0] cfg;
  wire fdx = cfg[`MPSRC_CFG_FDX];
  wire rep = cfg[`MPSRC_CFG_REP];
  wire sqe_sup = cfg[`MPSRC_CFG_SQE_SUP];
  wire spd100 = cfg[`MPSRC_CFG_SPD100];

  // true when two zeros sit at least two places apart
  function two_sep_zeros;
    input [9:0] sym;
    integer i;
    reg seen;
    begin
      seen = 1'b0;
      two_sep_zeros = 1'b0;
      for (i = 2; i < 10; i = i + 1) begin
        seen = seen | ~sym[i-2];
        if (seen & ~sym[i]) begin
          two_sep_zeros = 1'b1;
        end
      end
    end
  endfunction

  // 10-bit symbol window shifted on each recovered line clock rise
  reg [9:0] sym_win;
  reg act100;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      sym_win <= 10'h3FF;
      act100 <= 1'b0;
    end else if (line_rise) begin
      sym_win <= {sym_win[8:0], s_sym};
      act100 <= two_sep_zeros({sym_win[8:0], s_sym});
    end
  end

  // receive activity depends on speed
  wire rx_act = spd100 ? act100 : s_unsq;

  // quality error test: a delayed pulse after each transmission at 10 mb/s
  reg [15:0] sqe_cnt;
  reg sqe_wait;
  reg sqe_on;
  reg txen_d;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      sqe_cnt <= 16'h0000;
      sqe_wait <= 1'b0;
      sqe_on <= 1'b0;
      txen_d <= 1'b0;
    end else begin
      txen_d <= s_txen;
      if (txen_d & ~s_txen & ~sqe_sup & ~spd100 & ~fdx) begin
        sqe_wait <= 1'b1;
        sqe_on <= 1'b0;
        sqe_cnt <= SQE_WAIT;
      end else if (sqe_wait) begin
        if (sqe_cnt == 16'h0001) begin
          sqe_wait <= 1'b0;
          sqe_on <= 1'b1;
          sqe_cnt <= SQE_LEN;
        end else begin
          sqe_cnt <= sqe_cnt - 16'h0001;
        end
      end else if (sqe_on) begin
        if (sqe_cnt == 16'h0001) begin
          sqe_on <= 1'b0;
        end
        sqe_cnt <= sqe_cnt - 16'h0001;
      end
    end
  end

  // status outputs run on clk, free of both mii clocks
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      col <= 1'b0;
      crs <= 1'b0;
    end else begin
      col <= ~fdx & ((rx_act & s_txen) | sqe_on);
      if (fdx | rep) begin
        crs <= rx_act;
      end else begin
        crs <= rx_act | s_txen;
      end
    end
  end

  // receive clock source choice and realignment
  reg src_line;
  reg aligned;
  reg link_seen;
  reg [3:0] div;
  reg next_rx_clk;
  wire src_edge = src_line ? line_edge : ref_edge;
  wire crs_rise;
  reg crs_d;
  assign crs_rise = crs & ~crs_d;
  always @* begin
    next_rx_clk = rx_clk;
    if (src_edge) begin
      if (spd100) begin
        next_rx_clk = src_line ? lclk_b : s_ref;
      end else if (div == `MPSRC_HALF10 - 4'd1) begin
        next_rx_clk = ~rx_clk;
      end
    end
  end
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      src_line <= 1'b0;
      aligned <= 1'b1;
      link_seen <= 1'b0;
      div <= 4'd0;
      rx_clk <= 1'b0;
      crs_d <= 1'b0;
    end else begin
      crs_d <= crs;
      if (spd100) begin
        // follow the line while linked, the reference otherwise
        src_line <= s_link;
        link_seen <= s_link;
        aligned <= 1'b1;
        if (s_link & ~link_seen) begin
          div <= 4'd0;
        end
        rx_clk <= next_rx_clk;
      end else if (crs_rise) begin
        // lock to the packet: source switches after carrier sense
        src_line <= 1'b1;
        aligned <= 1'b0;
      end else if (~aligned & line_edge) begin
        div <= 4'd0;
        rx_clk <= 1'b0;
        aligned <= 1'b1;
      end else begin
        if (~crs & src_line) begin
          // keep running on the reference with the phase of the last packet
          src_line <= 1'b0;
        end
        if (src_edge) begin
          div <= (div == `MPSRC_HALF10 - 4'd1) ? 4'd0 : div + 4'd1;
        end
        rx_clk <= next_rx_clk;
      end
    end
  end
  // output data changes on the falling receive clock, stable at the rise
  wire rx_tick = rx_clk & ~next_rx_clk & aligned;

  // receive valid state from delimiters
  reg dv_state;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      dv_state <= 1'b0;
    end else if (dec_eof | dec_sig_err) begin
      dv_state <= 1'b0;
    end else if (dec_sof) begin
      dv_state <= 1'b1;
    end
  end

  // decoder words wait in the buffer for the next receive clock tick
  wire buf_valid;
  wire [5:0] buf_data;
  wire [5:0] buf_in;
  assign buf_in = {dec_sig_err & spd100, dv_state, dec_nibble};
  mpsrc_buf2 #(
    .W(6)
  ) u_buf (
    .clk(clk),
    .rst(rst),
    .in_valid(dec_valid),
    .in_ready(dec_ready),
    .in_data(buf_in),
    .out_valid(buf_valid),
    .out_ready(rx_tick),
    .out_data(buf_data)
  );
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_d <= 4'h0;
      rx_dv <= 1'b0;
      rx_er <= 1'b0;
    end else if (rx_tick) begin
      rx_d <= buf_valid ? buf_data[3:0] : 4'h0;
      rx_dv <= buf_valid & buf_data[4];
      rx_er <= buf_valid & buf_data[5];
    end
  end

  // management frame slave, paced by station clock rises
  reg [4:0] mst;
  reg [5:0] mcnt;
  reg [13:0] mhdr;
  reg [15:0] mshift;
  reg mread;
  reg mhit;
  wire [4:0] m_reg = mhdr[4:0];
  wire m_cfg = ({1'b0, m_reg} == `MPSRC_CFG_IDX);
  wire m_stat = ({1'b0, m_reg} == `MPSRC_STAT_IDX);
  wire [15:0] stat_word;
  assign stat_word = {9'h000, src_line, s_link, rx_dv, crs, col, act100, s_unsq};
  wire m_wr = (mst == M_DAT) & mdc_rise & (mcnt == 6'd15) & ~mread & mhit & m_cfg;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      mst <= M_PRE;
      mcnt <= 6'd0;
      mhdr <= 14'h0000;
      mshift <= 16'h0000;
      mread <= 1'b0;
      mhit <= 1'b0;
      mdio_o <= 1'b0;
      mdio_oe <= 1'b0;
    end else if (mdc_rise) begin
      case (mst)
        M_PRE: begin
          mdio_oe <= 1'b0;
          if (s_mdio) begin
            mcnt <= (mcnt == `MPSRC_PREAMBLE) ? mcnt : mcnt + 6'd1;
          end else if (mcnt == `MPSRC_PREAMBLE) begin
            mst <= M_HDR; // start bit zero after full preamble
            mcnt <= 6'd0;
          end else begin
            mcnt <= 6'd0;
          end
        end
        M_HDR: begin
          mhdr <= {mhdr[12:0], s_mdio};
          mcnt <= mcnt + 6'd1;
          if (mcnt == 6'd12) begin
            // bits: start1, op2, phy5, reg5
            // last register bit is still on the line, so fields sit one place low
            mread <= (mhdr[10:9] == 2'b10);
            mhit <= (mhdr[8:4] == PHY_ADDR);
            mst <= M_TA;
            mcnt <= 6'd0;
          end
        end
        M_TA: begin
          mcnt <= mcnt + 6'd1;
          mshift <= m_cfg ? cfg : (m_stat ? stat_word : 16'h0000);
          if (mread & mhit & mcnt == 6'd0) begin
            mdio_oe <= 1'b1; // turnaround low bit
            mdio_o <= 1'b0;
          end
          if (mcnt == 6'd1) begin
            mst <= M_DAT;
            mcnt <= 6'd0;
            if (mread & mhit) begin
              mdio_o <= mshift[15];
            end
          end
        end
        M_DAT: begin
          mcnt <= mcnt + 6'd1;
          if (mread) begin
            mdio_o <= mshift[14];
            mshift <= {mshift[14:0], 1'b0};
          end else begin
            mshift <= {mshift[14:0], s_mdio};
          end
          if (mcnt == 6'd15) begin
            mst <= M_END;
          end
        end
        M_END: begin
          mdio_oe <= 1'b0; // release the line after the last bit
          mst <= M_PRE;
          mcnt <= 6'd0;
        end
        default: begin
          mst <= M_PRE;
        end
      endcase
    end
  end

  // wishbone slave: one wait state, unmapped reads return zero
  wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wb_cfg = (wb_adr_i[7:2] == `MPSRC_CFG_IDX);
  wire wb_stat = (wb_adr_i[7:2] == `MPSRC_STAT_IDX);
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= wb_req;
      if (wb_req & ~wb_we_i) begin
        if (wb_cfg) begin
          wb_dat_o <= {16'h0000, cfg};
        end else if (wb_stat) begin
          wb_dat_o <= {16'h0000, stat_word};
        end else begin
          wb_dat_o <= 32'h00000000;
        end
      end
    end
  end

  // config writes; bus wins over a management write in the same cycle
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg <= `MPSRC_CFG_RST;
    end else if (wb_ack_o & wb_cyc_i & wb_stb_i & wb_we_i & wb_cfg) begin
      // write lands at the edge where the master sees ack
      if (wb_sel_i[0]) begin
        cfg[7:0] <= wb_dat_i[7:0];
      end
      if (wb_sel_i[1]) begin
        cfg[15:8] <= wb_dat_i[15:8];
      end
    end else if (m_wr) begin
      cfg <= {mshift[14:0], s_mdio};
    end
  end
endmodule // mpsrc_top

// [mpsrc_top_checker.sv]
// port assertions for the mii status and receive clock block
// assumes mode bits change only through bus writes
module mpsrc_chk (
  input wire clk,
  input wire rst,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire wb_ack_o,
  input wire line_unsquelched,
  input wire tx_en,
  input wire col,
  input wire crs,
  input wire rx_clk,
  input wire [3:0] rx_d,
  input wire rx_dv
);
  reg [3:0] cfg;
  wire cfg_wr;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // mode copy, taken at the ack edge like the register itself
  assign cfg_wr = wb_ack_o && wb_cyc_i && wb_we_i && wb_sel_i[0] && wb_adr_i[7:2] == 6'h12;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg <= 4'h0;
    end else if (cfg_wr) begin
      cfg <= wb_dat_i[3:0];
    end
  end
  // five samples cover two sync flops and the output register
  AST_COL_DET: assert property (
    (!cfg[0] && !cfg[3] && tx_en && line_unsquelched) [*5] |-> col)
    else $error("collision not raised");
  AST_COL_FDX: assert property (
    cfg[0] [*5] |-> !col)
    else $error("collision seen in full duplex");
  AST_SQE_OFF: assert property (
    ((cfg[2] || cfg[3]) && !tx_en) [*5] |-> !col)
    else $error("test pulse while suppressed");
  AST_CRS_HDX: assert property (
    (!cfg[0] && !cfg[1] && tx_en) [*5] |-> crs)
    else $error("carrier missing on transmit");
  AST_CRS_RX: assert property (
    ((cfg[0] || cfg[1]) && !cfg[3] && !line_unsquelched) [*5] |-> !crs)
    else $error("carrier without receive activity");
  AST_RX_EDGE: assert property (
    !$stable({rx_dv, rx_d}) |-> $fell(rx_clk))
    else $error("receive data moved off the clock fall");
  AST_ACK_LAT: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  AST_ACK_ONE: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  CV_COL: cover property ($rose(col));
  CV_DV: cover property ($rose(rx_dv));
  CV_WR: cover property (cfg_wr);
endmodule // mpsrc_chk

bind mpsrc_top mpsrc_chk u_chk (
  .clk(clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o),
  .line_unsquelched(line_unsquelched), .tx_en(tx_en), .col(col), .crs(crs),
  .rx_clk(rx_clk), .rx_d(rx_d), .rx_dv(rx_dv)
);

// [mpsrc_line_model.sv]
// line side model: local reference and framed line symbol clock
// assumes nothing of the bench clock; timing is free delay
module mpsrc_line_model (
  output logic ref_in,
  output logic line_sym_clk,
  output logic line_sym_bit
);
  timeunit 1ns;
  timeprecision 100ps;
  // 25 mhz board oscillator, offset so it never meets clk edges
  initial begin
    ref_in = 1'b0;
    #1.3;
    forever #20 ref_in = ~ref_in;
  end
  initial begin
    line_sym_clk = 1'b0;
    line_sym_bit = 1'b1;
  end
  // one symbol per call; the clock stands still between symbols
  task send(input [9:0] s);
    integer i;
    begin
      #0.7;
      for (i = 9; i >= 0; i--) begin
        line_sym_bit = s[i];
        #62.5 line_sym_clk = 1'b1;
        #62.5 line_sym_clk = 1'b0;
      end
      line_sym_bit = ~s[0]; // stale bit never passes as held
    end
  endtask
endmodule // mpsrc_line_model

// [mpsrc_bench.sv]
// self-checking bench for the mii status and receive clock block
// assumes the line model makes the reference and line clocks
module mpsrc_bench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam [55:0] TBL = 56'h4F491D1868656F;
  localparam [45:0] FRAME = {32'hFFFFFFFF, 14'h1832};
  reg clk, rst, cyc, stb, we, unsq, link, dv, sof, eof, serr, tx_en, mdc, st_oe, st_o;
  reg [7:0] adr, row;
  reg [3:0] sel, nib;
  reg [31:0] wdat, rd;
  reg [15:0] md;
  reg [3:0] got[$];
  wire [31:0] dat_o;
  wire [3:0] rx_d;
  wire ack, dec_rdy, col, crs, rx_clk, rx_dv, rx_er, mdo, mdoe, sclk, sbit, ref_in, mdio;
  integer err_count = 0, total_checks = 0, k, stall, rises;
  // shared line with pull-up
  assign mdio = mdoe ? mdo : (st_oe ? st_o : 1'b1);
  mpsrc_line_model u_line (.ref_in(ref_in), .line_sym_clk(sclk), .line_sym_bit(sbit));
  mpsrc_top #(.PHY_ADDR(5'h01)) u_dut (
    .clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .line_unsquelched(unsq), .line_sym_clk(sclk), .line_sym_bit(sbit),
    .line_link(link), .ref_in(ref_in), .dec_valid(dv), .dec_ready(dec_rdy),
    .dec_nibble(nib), .dec_sof(sof), .dec_eof(eof), .dec_sig_err(serr),
    .tx_en(tx_en), .col(col), .crs(crs), .rx_clk(rx_clk), .rx_d(rx_d),
    .rx_dv(rx_dv), .rx_er(rx_er), .mdc(mdc), .mdio_i(mdio), .mdio_o(mdo), .mdio_oe(mdoe)
  );
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // receive side of the mac: nibbles taken on the rise, phase jumps tolerated
  always @(posedge rx_clk) begin
    rises = rises + 1;
    if (rx_dv === 1'b1) got.push_back(rx_d);
  end
  task check(input [31:0] seen, input [31:0] exp, input string what);
    begin
      total_checks = total_checks + 1;
      if (seen !== exp) begin
        err_count = err_count + 1;
        $display("CHECK FAILED %0s expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  task print_verdict;
    begin
      $display("checks %0d errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
        $display("DONE - PASS");
      end else begin
        $display("DONE - FAIL");
      end
      $finish;
    end
  endtask
  // classic single cycle; waits for ack, no assumed latency
  task wb(input w, input [7:0] a, input [31:0] d);
    integer t;
    begin
      t = 0;
      @(posedge clk);
      {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
      @(posedge clk);
      while (ack !== 1'b1 && t < 20) begin
        @(posedge clk);
        t = t + 1;
      end
      check(ack, 1, "wb ack");
      rd = dat_o;
      {cyc, stb} <= 2'b00;
      @(posedge clk);
    end
  endtask
  task mode(input [3:0] m);
    wb(1'b1, 8'h48, {28'h0, m});
  endtask
  // pins need sync time before the outputs follow
  task pins(input t, input u);
    begin
      @(posedge clk);
      {tx_en, unsq} <= {t, u};
      repeat (8) @(posedge clk);
    end
  endtask
  task tick(input integer n);
    repeat (n) @(posedge clk);
  endtask
  // station owns mdc; line is sampled late in the low phase
  task mdbit(input b);
    begin
      {mdc, st_o} <= {1'b0, b};
      tick(10);
      md = {md[14:0], mdio};
      mdc <= 1'b1;
      tick(10);
    end
  endtask
  initial begin
    {cyc, stb, we, unsq, link, dv, sof, eof, serr, tx_en, mdc, st_oe, st_o} = 13'h0000;
    {adr, row, sel, nib, wdat, md} = 72'h0;
    sel = 4'hF;
    rises = 0;
    stall = 0;
    rst = 1'b1;
    tick(10);
    rst <= 1'b0;
    wb(1'b0, 8'h48, 32'h0);
    check(rd, 32'h0, "cfg reset");
    wb(1'b1, 8'hF0, 32'hFFFFFFFF);
    wb(1'b0, 8'hF0, 32'h0);
    check(rd, 32'h0, "unmapped");
    wb(1'b1, 8'h4C, 32'hFFFFFFFF);
    wb(1'b0, 8'h4C, 32'h0);
    check(rd & 32'hFFFFFFBD, 32'h0, "status idle");
    // rows: mode, tx_en, activity, expected col and crs
    for (k = 0; k < 7; k++) begin
      row = TBL[8*(6-k) +: 8];
      mode(row[7:4]);
      pins(row[3], row[2]);
      check(col, row[1], "col");
      check(crs, row[0], "crs");
    end
    mode(4'h0);
    pins(1'b1, 1'b0);
    pins(1'b0, 1'b0);
    tick(210);
    check(col, 1, "test pulse on");
    tick(200);
    check(col, 0, "test pulse off");
    mode(4'h4);
    pins(1'b1, 1'b0);
    pins(1'b0, 1'b0);
    tick(210);
    check(col, 0, "test pulse held");
    mode(4'h8);
    pins(1'b1, 1'b0);
    u_line.send(10'h3EF);
    tick(8);
    check(col, 0, "one zero");
    u_line.send(10'h37B);
    tick(8);
    check(col, 1, "two zeros");
    pins(1'b0, 1'b0);
    rises = 0;
    tick(800);
    check(rises >= 99 && rises <= 101, 1, "rx_clk 100");
    // burst faster than the clock drains: buffer must push back
    @(posedge clk);
    sof <= 1'b1;
    @(posedge clk);
    {sof, dv, nib} <= {2'b01, 4'h1};
    k = 1;
    while (k < 7 && stall < 400) begin
      @(posedge clk);
      if (dec_rdy === 1'b1) begin
        k = k + 1;
        nib <= k[3:0];
      end else begin
        stall = stall + 1;
      end
    end
    {dv, eof} <= 2'b01;
    @(posedge clk);
    eof <= 1'b0;
    tick(300);
    check(stall > 0, 1, "push back");
    check(got.size(), 6, "rx count");
    for (k = 0; k < 6; k++) check(got[k], k + 1, "rx nibble");
    check(rx_dv, 0, "rx_dv end");
    check(rx_er, 0, "rx_er clean");
    st_oe <= 1'b1;
    for (k = 0; k < 46; k++) mdbit(FRAME[45-k]);
    st_oe <= 1'b0;
    for (k = 0; k < 18; k++) mdbit(1'b1);
    check(md, 16'h0008, "mdio read");
    mode(4'h0);
    rises = 0;
    tick(800);
    check(rises >= 9 && rises <= 11, 1, "rx_clk 10");
    print_verdict;
  end
  // hang guard, well beyond the expected run
  initial begin
    tick(40000);
    err_count = err_count + 1;
    print_verdict;
  end
endmodule // mpsrc_bench
